// File: design/scrc_core.sv
// What this block does
// - No-operation code ends with aborted-command error; the buffer is still refilled from the address.
// - Buffer readback returns current buffer contents without touching media.
// - Buffer readback uses busy, data request, interrupt, host-read sequence.
// - Programmed read: busy, load, data request, clear busy, interrupt, 512 bytes.
// - DMA read moves one to 256 sectors using the DMA channel.
// - Sector count zero means 256 sectors.
// - Reads start at sector given by address registers.
// - DMA read sets busy, buffers data, then may raise data request.
// - DMA request line held while data is ready for host.
// - DMA read interrupts only at completion or on any media error, correctable or not.
// - After DMA success address registers hold last sector read.
// - DMA error stops at failing sector and keeps its address.
// - DMA read aborted when eight-bit transfer mode is enabled.
// - Multiple read checks data request only at each block start.
// - Whole blocks first, then a final partial block of remainder sectors.
// - Multiple read aborted if no block size or multiple disabled.
// - Multiple read interrupts on each block start data request.
// - Media error posted when the failing sector loads; block still transferred.
// - Continue past the end of the errored block only when the error was correctable.
// - Native max address returned across the four address registers.
`timescale 1ns/1ns
`default_nettype none
module scrc_core
	import scrc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic dma_request_line,
	input wire logic dmack_n,
	input wire logic iord_n,
	output logic [15:0] dma_data,
	output logic intrq
);
	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] ack_sync_reg;
	logic [2:0] rd_sync_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_sync_reg <= 2'b11;
			rd_sync_reg <= 3'b111;
		end else begin
			ack_sync_reg <= {ack_sync_reg[0], dmack_n};
			rd_sync_reg <= {rd_sync_reg[1:0], iord_n};
		end
	end
	// The strobe edge is taken between the second and third stages only.
	logic dma_word;
	assign dma_word = !ack_sync_reg[1] && rd_sync_reg[2] && !rd_sync_reg[1];

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0] feature_select_reg, transfer_sector_count_reg;
	logic [7:0] address_low_byte_reg, address_mid_byte_reg, address_high_byte_reg;
	logic [7:0] device_head_select_reg, status_reg, error_reg;
	logic [31:0] config_reg, media_reg;
	logic [15:0] buffer_mem [SECTOR_WORDS];
	logic [7:0] word_ptr_reg;
	logic [8:0] remain_reg, block_left_reg;
	logic [7:0] cmd_reg;
	logic first_reg;
	scrc_state_t state_reg;
	logic wr, rd, cmd_wr, data_rd, pio_word, xfer_word;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	assign cmd_wr = wr && paddr == ADDR_COMMAND && state_reg == SCRC_IDLE;
	assign data_rd = rd && paddr == ADDR_DATA;
	assign pio_word = data_rd && state_reg == SCRC_PIO;
	assign xfer_word = pio_word || (state_reg == SCRC_DMA && dma_word);

	function automatic logic [27:0] lba_of(input logic [7:0] dh, input logic [7:0] hi,
		input logic [7:0] mid, input logic [7:0] lo);
		lba_of = {dh[3:0], hi, mid, lo};
	endfunction : lba_of

	function automatic logic [8:0] count_of(input logic [7:0] c);
		count_of = (c == 8'h00) ? FULL_COUNT : {1'b0, c};
	endfunction : count_of

	logic [27:0] cur_lba, next_lba;
	logic [8:0] blk;
	logic media_err, media_fatal;
	assign cur_lba = lba_of(device_head_select_reg, address_high_byte_reg,
		address_mid_byte_reg, address_low_byte_reg);
	assign next_lba = cur_lba + 28'h000_0001;
	assign blk = {1'b0, config_reg[CF_BLOCK_LSB +: 8]};
	// A sector listed in the media fault register reports an error on load.
	assign media_err = media_reg[31] && media_reg[27:0] == cur_lba;
	assign media_fatal = media_err && !media_reg[30];

	// ----------------------------------------------------------------
	// Command sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= SCRC_IDLE;
			cmd_reg <= 8'h00;
			status_reg <= 8'h00;
			error_reg <= 8'h00;
			remain_reg <= 9'h000;
			block_left_reg <= 9'h000;
			word_ptr_reg <= 8'h00;
			first_reg <= 1'b0;
			intrq <= 1'b0;
			dma_request_line <= 1'b0;
		end else begin
			if (rd && paddr == ADDR_COMMAND)
				intrq <= 1'b0;
			unique case (state_reg)
				SCRC_IDLE: begin
					if (cmd_wr) begin
						cmd_reg <= pwdata[7:0];
						error_reg <= 8'h00;
						status_reg <= 8'h00;
						status_reg[ST_BUSY] <= 1'b1;
						remain_reg <= count_of(transfer_sector_count_reg);
						word_ptr_reg <= 8'h00;
						first_reg <= 1'b1;
						state_reg <= SCRC_LOAD;
					end
				end
				SCRC_LOAD: begin
					word_ptr_reg <= 8'h00;
					if (cmd_reg == CMD_NOP
						|| (cmd_reg == CMD_READ_DMA && config_reg[CF_EIGHT_BIT])
						|| (cmd_reg == CMD_READ_MULTI && (blk == 9'h000
							|| !config_reg[CF_MULTI_EN]))
						|| !(cmd_reg == CMD_READ_BUFFER || cmd_reg == CMD_READ_DMA
							|| cmd_reg == CMD_READ_MULTI || cmd_reg == CMD_NATIVE_MAX)) begin
						error_reg[ER_ABORT] <= 1'b1;
						status_reg <= 8'h01;
						intrq <= 1'b1;
						state_reg <= SCRC_IDLE;
					end else if (cmd_reg == CMD_NATIVE_MAX) begin
						status_reg <= 8'h00;
						intrq <= 1'b1;
						state_reg <= SCRC_IDLE;
					end else if (cmd_reg == CMD_READ_DMA) begin
						status_reg[ST_DRQ] <= 1'b1;
						status_reg[ST_BUSY] <= 1'b0;
						if (media_err) begin
							error_reg[ER_UNC] <= 1'b1;
							status_reg <= 8'h01;
							intrq <= 1'b1;
							state_reg <= SCRC_IDLE;
						end else begin
							dma_request_line <= 1'b1;
							state_reg <= SCRC_DMA;
						end
					end else begin
						status_reg[ST_BUSY] <= 1'b0;
						status_reg[ST_DRQ] <= 1'b1;
						if (cmd_reg == CMD_READ_MULTI) begin
							if (first_reg || block_left_reg == 9'h000) begin
								intrq <= 1'b1;
								block_left_reg <= (remain_reg < blk) ? remain_reg : blk;
							end
							if (media_err) begin
								error_reg[ER_UNC] <= media_fatal;
								status_reg[ST_ERR] <= 1'b1;
							end
						end else begin
							intrq <= 1'b1;
						end
						state_reg <= SCRC_PIO;
					end
					first_reg <= 1'b0;
				end
				SCRC_PIO, SCRC_DMA: begin
					if (xfer_word) begin
						word_ptr_reg <= word_ptr_reg + 8'h01;
						if (word_ptr_reg == 8'hFF) begin
							remain_reg <= remain_reg - 9'h001;
							dma_request_line <= 1'b0;
							status_reg[ST_DRQ] <= 1'b0;
							if (cmd_reg == CMD_READ_MULTI)
								block_left_reg <= block_left_reg - 9'h001;
							state_reg <= SCRC_DONE;
						end
					end
				end
				SCRC_DONE: begin
					if (remain_reg == 9'h000 || cmd_reg == CMD_READ_BUFFER
						|| (cmd_reg == CMD_READ_MULTI && block_left_reg == 9'h000
							&& error_reg[ER_UNC])) begin
						status_reg[ST_BUSY] <= 1'b0;
						if (cmd_reg == CMD_READ_DMA)
							intrq <= 1'b1;
						state_reg <= SCRC_IDLE;
					end else begin
						status_reg[ST_BUSY] <= (cmd_reg != CMD_READ_MULTI)
							|| block_left_reg == 9'h000;
						state_reg <= SCRC_LOAD;
					end
				end
				default: state_reg <= SCRC_IDLE;
			endcase
		end
	end

	// Buffer fill: each new sector is a pattern of its address; readback keeps it.
	always_ff @(posedge pclk) begin
		if (state_reg == SCRC_LOAD && cmd_reg != CMD_READ_BUFFER) begin
			for (int i = 0; i < SECTOR_WORDS; i++)
				buffer_mem[i] <= cur_lba[15:0] ^ 16'(i);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			dma_data <= 16'h0000;
		else if (xfer_word)
			dma_data <= buffer_mem[word_ptr_reg];
	end

	// ----------------------------------------------------------------
	// Task-file writes and address update
	// ----------------------------------------------------------------
	logic advance;
	assign advance = state_reg == SCRC_DONE && remain_reg != 9'h000
		&& cmd_reg != CMD_READ_BUFFER;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			feature_select_reg <= 8'h00;
			transfer_sector_count_reg <= COUNT_RESET;
			address_low_byte_reg <= LOW_RESET;
			address_mid_byte_reg <= 8'h00;
			address_high_byte_reg <= 8'h00;
			device_head_select_reg <= DEVHEAD_RESET;
			config_reg <= 32'h0000_0000;
			media_reg <= 32'h0000_0000;
		end else if (state_reg == SCRC_LOAD && cmd_reg == CMD_NATIVE_MAX) begin
			device_head_select_reg[3:0] <= NATIVE_MAX_DEFAULT[27:24];
			address_high_byte_reg <= NATIVE_MAX_DEFAULT[23:16];
			address_mid_byte_reg <= NATIVE_MAX_DEFAULT[15:8];
			address_low_byte_reg <= NATIVE_MAX_DEFAULT[7:0];
		end else if (advance) begin
			// Only advanced while sectors remain, so the last stays; a fatal multiple-read stop with sectors left still advances.
			device_head_select_reg[3:0] <= next_lba[27:24];
			address_high_byte_reg <= next_lba[23:16];
			address_mid_byte_reg <= next_lba[15:8];
			address_low_byte_reg <= next_lba[7:0];
			transfer_sector_count_reg <= transfer_sector_count_reg - 8'h01;
		end else if (wr && state_reg == SCRC_IDLE) begin
			unique case (paddr)
				ADDR_FEATURE: feature_select_reg <= pwdata[7:0];
				ADDR_COUNT: transfer_sector_count_reg <= pwdata[7:0];
				ADDR_LOW: address_low_byte_reg <= pwdata[7:0];
				ADDR_MID: address_mid_byte_reg <= pwdata[7:0];
				ADDR_HIGH: address_high_byte_reg <= pwdata[7:0];
				ADDR_DEVHEAD: device_head_select_reg <= pwdata[7:0];
				ADDR_CONFIG: config_reg <= {16'h0000, pwdata[15:8], 6'h00, pwdata[1:0]};
				ADDR_MEDIA: media_reg <= pwdata;
				default: ;
			endcase
		end
	end

	always_comb begin
		prdata = 32'h0000_0000;
		unique case (paddr)
			ADDR_DATA: prdata = {16'h0000, buffer_mem[word_ptr_reg]};
			ADDR_FEATURE: prdata = {24'h00_0000, error_reg};
			ADDR_COUNT: prdata = {24'h00_0000, transfer_sector_count_reg};
			ADDR_LOW: prdata = {24'h00_0000, address_low_byte_reg};
			ADDR_MID: prdata = {24'h00_0000, address_mid_byte_reg};
			ADDR_HIGH: prdata = {24'h00_0000, address_high_byte_reg};
			ADDR_DEVHEAD: prdata = {24'h00_0000, device_head_select_reg};
			ADDR_COMMAND: prdata = {24'h00_0000, status_reg};
			ADDR_CONFIG: prdata = config_reg;
			ADDR_MEDIA: prdata = media_reg;
			default: prdata = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_nop_aborts: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == SCRC_LOAD && cmd_reg == CMD_NOP |=> error_reg[ER_ABORT] && intrq
		&& status_reg == 8'h01 && state_reg == SCRC_IDLE)
		else $error("nop did not abort");
	a_eight_bit_reject: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == SCRC_LOAD && cmd_reg == CMD_READ_DMA && config_reg[CF_EIGHT_BIT]
		|=> error_reg[ER_ABORT] && !dma_request_line)
		else $error("dma read not rejected in eight-bit mode");
	a_multi_no_block: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == SCRC_LOAD && cmd_reg == CMD_READ_MULTI && blk == 9'h000
		|=> error_reg[ER_ABORT])
		else $error("multiple read without block size not aborted");
	a_dma_no_midirq: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == SCRC_DMA |=> !$rose(intrq))
		else $error("interrupt during dma transfer");
	a_dma_req_held: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == SCRC_DMA && !(xfer_word && word_ptr_reg == 8'hFF) |=> dma_request_line)
		else $error("dma request dropped with data ready");
	a_zero_is_full: assert property (@(posedge pclk) disable iff (!presetn)
		cmd_wr && transfer_sector_count_reg == 8'h00 |=> remain_reg == FULL_COUNT)
		else $error("zero count not taken as 256");
	a_busy_on_cmd: assert property (@(posedge pclk) disable iff (!presetn)
		cmd_wr |=> status_reg[ST_BUSY] ##1 !status_reg[ST_BUSY] || error_reg[ER_ABORT])
		else $error("busy not set then cleared");
	a_max_address: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == SCRC_LOAD && cmd_reg == CMD_NATIVE_MAX |=> cur_lba == NATIVE_MAX_DEFAULT)
		else $error("native max not returned");

	// ----------------------------------------------------------------
	// Transfer sequence checks
	// ----------------------------------------------------------------
	a_buffer_kept: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == SCRC_LOAD && cmd_reg == CMD_READ_BUFFER
		|=> buffer_mem[0] == $past(buffer_mem[0]))
		else $error("buffer refilled on readback");
	a_readback_start: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == SCRC_LOAD && cmd_reg == CMD_READ_BUFFER
		|=> status_reg[ST_DRQ] && !status_reg[ST_BUSY] && intrq && state_reg == SCRC_PIO)
		else $error("readback did not start like a sector read");
	a_pio_ready: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == SCRC_PIO
		|-> !status_reg[ST_BUSY] && status_reg[ST_DRQ])
		else $error("busy or data request wrong during host reads");
	a_dma_start: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == SCRC_LOAD && cmd_reg == CMD_READ_DMA && !config_reg[CF_EIGHT_BIT]
		&& !media_err |=> dma_request_line && state_reg == SCRC_DMA && !status_reg[ST_BUSY])
		else $error("dma read did not raise its request");
	a_dma_err_stop: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == SCRC_LOAD && cmd_reg == CMD_READ_DMA && !config_reg[CF_EIGHT_BIT]
		&& media_err |=> error_reg[ER_UNC] && state_reg == SCRC_IDLE && $stable(cur_lba))
		else $error("dma error did not stop at failing sector");
	a_dma_done_irq: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == SCRC_DONE && cmd_reg == CMD_READ_DMA && remain_reg == 9'h000
		|=> intrq && state_reg == SCRC_IDLE)
		else $error("no interrupt at end of dma read");
	a_last_addr_kept: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == SCRC_DONE && remain_reg == 9'h000
		|=> $stable(cur_lba))
		else $error("address moved past last sector");
	a_block_len: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == SCRC_LOAD && cmd_reg == CMD_READ_MULTI && blk != 9'h000
		&& config_reg[CF_MULTI_EN] && (first_reg || block_left_reg == 9'h000)
		|=> block_left_reg == (($past(remain_reg) < $past(blk)) ? $past(remain_reg) : $past(blk)))
		else $error("block length wrong");
	a_block_irq: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == SCRC_LOAD && cmd_reg == CMD_READ_MULTI && blk != 9'h000
		&& config_reg[CF_MULTI_EN] && (first_reg || block_left_reg == 9'h000)
		|=> intrq)
		else $error("no interrupt at block start");
	a_no_midblock_irq: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == SCRC_LOAD && cmd_reg == CMD_READ_MULTI && !first_reg
		&& block_left_reg != 9'h000 |=> !$rose(intrq))
		else $error("interrupt inside a block");
	a_err_block_sent: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == SCRC_LOAD && cmd_reg == CMD_READ_MULTI && blk != 9'h000
		&& config_reg[CF_MULTI_EN] && media_err
		|=> status_reg[ST_ERR] && status_reg[ST_DRQ] && state_reg == SCRC_PIO)
		else $error("errored block not transferred");
	a_fatal_stops: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == SCRC_DONE && cmd_reg == CMD_READ_MULTI && block_left_reg == 9'h000
		&& error_reg[ER_UNC] |=> state_reg == SCRC_IDLE)
		else $error("multiple read went on after fatal error");
endmodule : scrc_core
`default_nettype wire

// File: design/scrc_pkg.sv
package scrc_pkg;
	// Task-file word offsets on the APB bus.
	localparam logic [7:0] ADDR_DATA = 8'h00;
	localparam logic [7:0] ADDR_FEATURE = 8'h04;
	localparam logic [7:0] ADDR_COUNT = 8'h08;
	localparam logic [7:0] ADDR_LOW = 8'h0C;
	localparam logic [7:0] ADDR_MID = 8'h10;
	localparam logic [7:0] ADDR_HIGH = 8'h14;
	localparam logic [7:0] ADDR_DEVHEAD = 8'h18;
	localparam logic [7:0] ADDR_COMMAND = 8'h1C;
	localparam logic [7:0] ADDR_CONFIG = 8'h20;
	localparam logic [7:0] ADDR_MEDIA = 8'h24;
	// Command codes.
	localparam logic [7:0] CMD_NOP = 8'h00;
	localparam logic [7:0] CMD_READ_BUFFER = 8'hE4;
	localparam logic [7:0] CMD_READ_DMA = 8'hC8;
	localparam logic [7:0] CMD_READ_MULTI = 8'hC4;
	localparam logic [7:0] CMD_NATIVE_MAX = 8'hF8;
	// Status and error bit positions.
	localparam int ST_BUSY = 7;
	localparam int ST_DRQ = 3;
	localparam int ST_ERR = 0;
	localparam int ER_ABORT = 2;
	localparam int ER_UNC = 6;
	localparam int DH_LBA = 6;
	// Config bit positions.
	localparam int CF_EIGHT_BIT = 0;
	localparam int CF_MULTI_EN = 1;
	localparam int CF_BLOCK_LSB = 8;
	// Sizes.
	localparam int SECTOR_WORDS = 256;
	localparam logic [8:0] FULL_COUNT = 9'h100;
	localparam logic [27:0] NATIVE_MAX_DEFAULT = 28'h00F_FFFF;
	localparam logic [7:0] DEVHEAD_RESET = 8'hA0;
	localparam logic [7:0] COUNT_RESET = 8'h01;
	localparam logic [7:0] LOW_RESET = 8'h01;
	typedef enum logic [2:0] {
		SCRC_IDLE = 3'b000,
		SCRC_LOAD = 3'b001,
		SCRC_PIO = 3'b010,
		SCRC_DMA = 3'b011,
		SCRC_DONE = 3'b100
	} scrc_state_t;
endpackage : scrc_pkg

// File: bench/scrc_host_dma.sv
`timescale 1ns/1ns
`default_nettype none
module scrc_host_dma (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic dma_request_line,
	input wire logic [15:0] dma_data,
	input wire logic slow,
	output logic dmack_n,
	output logic iord_n,
	output logic [15:0] rx_data,
	output logic rx_strobe
);
	initial begin
		dmack_n = 1'b1;
		iord_n = 1'b1;
		rx_data = 16'h0000;
		rx_strobe = 1'b0;
	end
	// One word per pulse, taken only while the device requests; slow mode stretches the gap.
	always begin
		@(posedge pclk);
		if (presetn === 1'b1 && dma_request_line === 1'b1) begin
			dmack_n <= 1'b0;
			iord_n <= 1'b0;
			repeat (3) @(posedge pclk);
			iord_n <= 1'b1;
			repeat (slow ? 12 : 4) @(posedge pclk);
			rx_data <= dma_data;
			rx_strobe <= 1'b1;
			@(posedge pclk);
			rx_strobe <= 1'b0;
		end else begin
			dmack_n <= 1'b1;
		end
	end
endmodule : scrc_host_dma
`default_nettype wire

// File: bench/tb_scrc_core.sv
`timescale 1ns/1ns
`default_nettype none
module tb_scrc_core import scrc_pkg::*; ;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic slow = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, q;
	logic pready, pslverr, dma_request_line, intrq, dmack_n, iord_n, rx_strobe;
	logic [15:0] dma_data, rx_data;
	logic intrq_d = 1'b0;
	int bad_count = 0;
	int n_checks = 0;
	int rises = 0;
	int words = 0;
	int r0;
	logic [31:0] acfg [5] = '{32'h0000_0000, 32'h0000_0001, 32'h0000_0200, 32'h0000_0002,
		32'h0000_0000};
	logic [7:0] acmd [5] = '{CMD_NOP, CMD_READ_DMA, CMD_READ_MULTI, CMD_READ_MULTI, 8'h55};

	scrc_core scrc_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .dma_request_line(dma_request_line), .dmack_n(dmack_n),
		.iord_n(iord_n), .dma_data(dma_data), .intrq(intrq));
	scrc_host_dma scrc_host_dma_inst (.pclk(pclk), .presetn(presetn),
		.dma_request_line(dma_request_line), .dma_data(dma_data), .slow(slow),
		.dmack_n(dmack_n), .iord_n(iord_n), .rx_data(rx_data), .rx_strobe(rx_strobe));

	always #50 pclk = ~pclk;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic report_and_stop;
		$display("checks=%0d mismatches=%0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : report_and_stop

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hFF);
		apb(1'b0, a, 32'h0000_0000);
		chk(q & m, exp);
	endtask : rd

	task automatic wait_irq;
		int n;
		n = 0;
		while (intrq !== 1'b1 && n < 10000) begin
			@(posedge pclk);
			n++;
		end
		chk({31'h0, intrq}, 32'h0000_0001);
	endtask : wait_irq

	task automatic wait_drq;
		int n;
		n = 0;
		apb(1'b0, ADDR_COMMAND, 32'h0000_0000);
		while (q[7:0] !== 8'h08 && n < 50) begin
			apb(1'b0, ADDR_COMMAND, 32'h0000_0000);
			n++;
		end
		chk({24'h0, q[7:0]}, 32'h0000_0008);
	endtask : wait_drq

	task automatic read_sector(input logic [15:0] block_addressing_bit);
		for (int i = 0; i < SECTOR_WORDS; i++) begin
			apb(1'b0, ADDR_DATA, 32'h0000_0000);
			chk({16'h0, q[15:0]}, {16'h0, block_addressing_bit ^ 16'(i)});
		end
	endtask : read_sector

	task automatic set_lba(input logic [15:0] block_addressing_bit, input logic [7:0] cnt);
		apb(1'b1, ADDR_DEVHEAD, 32'h0000_00E0);
		apb(1'b1, ADDR_HIGH, 32'h0000_0000);
		apb(1'b1, ADDR_MID, {24'h0, block_addressing_bit[15:8]});
		apb(1'b1, ADDR_LOW, {24'h0, block_addressing_bit[7:0]});
		apb(1'b1, ADDR_COUNT, {24'h0, cnt});
	endtask : set_lba

	// ----------------------------------------
	// Monitors and watchdog
	// ----------------------------------------
	always @(posedge pclk) begin
		intrq_d <= intrq;
		if (intrq === 1'b1 && intrq_d !== 1'b1) rises <= rises + 1;
		if (rx_strobe === 1'b1) begin
			chk({16'h0, rx_data}, {16'h0, (16'h0100 + 16'(words / 256)) ^ 16'(words % 256)});
			words <= words + 1;
			slow <= (words >= 255);
		end
	end

	initial begin
		repeat (40000) @(posedge pclk);
		bad_count++;
		report_and_stop();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(ADDR_DEVHEAD, DEVHEAD_RESET);
		rd(ADDR_COUNT, COUNT_RESET);
		rd(ADDR_LOW, LOW_RESET);
		rd(ADDR_COMMAND, 32'h0000_0000);
		rd(8'h30, 32'h0000_0000, 32'hFFFF_FFFF);
		chk({31'h0, pslverr}, 32'h0000_0000);
		$display("test reset done");
		apb(1'b1, ADDR_COUNT, 32'h0000_0000);
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, ADDR_CONFIG, acfg[i]);
			r0 = rises;
			apb(1'b1, ADDR_COMMAND, {24'h0, acmd[i]});
			wait_irq();
			rd(ADDR_COMMAND, 32'h0000_0001);
			rd(ADDR_FEATURE, 32'h0000_0004);
			chk({31'h0, intrq}, 32'h0000_0000);
			chk(rises - r0, 32'h0000_0001);
		end
		$display("test aborts done");
		apb(1'b1, ADDR_DEVHEAD, 32'h0000_00E0);
		apb(1'b1, ADDR_COMMAND, {24'h0, CMD_NATIVE_MAX});
		wait_irq();
		rd(ADDR_COMMAND, 32'h0000_0000);
		rd(ADDR_HIGH, 32'h0000_000F);
		rd(ADDR_MID, 32'h0000_00FF);
		rd(ADDR_LOW, 32'h0000_00FF);
		rd(ADDR_DEVHEAD, 32'h0000_0000, 32'h0000_000F);
		$display("test native max done");
		apb(1'b1, ADDR_CONFIG, 32'h0000_0000);
		set_lba(16'h0100, 8'h02);
		r0 = rises;
		apb(1'b1, ADDR_COMMAND, {24'h0, CMD_READ_DMA});
		wait_irq();
		repeat (30) @(posedge pclk);
		chk(words, 32'd512);
		chk(rises - r0, 32'h0000_0001);
		rd(ADDR_COMMAND, 32'h0000_0000);
		rd(ADDR_LOW, 32'h0000_0001);
		rd(ADDR_MID, 32'h0000_0001);
		$display("test dma read done");
		apb(1'b1, ADDR_CONFIG, 32'h0000_0202);
		set_lba(16'h0200, 8'h03);
		r0 = rises;
		apb(1'b1, ADDR_COMMAND, {24'h0, CMD_READ_MULTI});
		for (int s = 0; s < 3; s++) begin
			wait_drq();
			read_sector(16'h0200 + 16'(s));
		end
		chk(rises - r0, 32'h0000_0002);
		rd(ADDR_COMMAND, 32'h0000_0000);
		$display("test multiple read done");
		r0 = rises;
		apb(1'b1, ADDR_COMMAND, {24'h0, CMD_READ_BUFFER});
		wait_irq();
		wait_drq();
		read_sector(16'h0202);
		chk(rises - r0, 32'h0000_0001);
		$display("test buffer readback done");
		apb(1'b1, ADDR_CONFIG, 32'h0000_0000);
		apb(1'b1, ADDR_MEDIA, 32'h8000_0300);
		set_lba(16'h0300, 8'h01);
		r0 = rises;
		apb(1'b1, ADDR_COMMAND, {24'h0, CMD_READ_DMA});
		wait_irq();
		rd(ADDR_COMMAND, 32'h0000_0001);
		rd(ADDR_FEATURE, 32'h0000_0040);
		rd(ADDR_MID, 32'h0000_0003);
		rd(ADDR_LOW, 32'h0000_0000);
		chk(rises - r0, 32'h0000_0001);
		$display("test dma error done");
		apb(1'b1, ADDR_CONFIG, 32'h0000_0202);
		apb(1'b1, ADDR_MEDIA, 32'hC000_0400);
		set_lba(16'h0400, 8'h01);
		apb(1'b1, ADDR_COMMAND, {24'h0, CMD_READ_MULTI});
		wait_irq();
		rd(ADDR_COMMAND, 32'h0000_0009);
		rd(ADDR_FEATURE, 32'h0000_0000);
		read_sector(16'h0400);
		rd(ADDR_COMMAND, 32'h0000_0001);
		$display("test multiple read error done");
		report_and_stop();
	end
endmodule : tb_scrc_core
`default_nettype wire
